// file: rtl/periodic_timer.sv
// Periodic interrupt timer: APB registers, modulus counter and interrupt request
`include "timer_params.svh"
module periodic_timer
  import timer_types_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic crystal_input,
  input logic clock_mode_pin,
  input logic iack,
  input logic [2:0] iack_level,
  input logic [2:0] ext_irq_level,
  output logic [2:0] timer_request_level,
  output logic vector_valid,
  output logic [7:0] vector_out,
  output logic ext_iack,
  output logic irq
);

  // ****************************************************************
  // Pin synchronisers and prescaler
  // ****************************************************************
  timer_state_t st;
  timer_state_t next_st;
  logic xtal_rise;
  logic mode_level;
  logic tick;
  logic expire;
  logic overrun;
  logic claim;
  logic wr;
  logic ctrl_wr;
  logic count_wr;

  pin_sync u_xtal_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(crystal_input),
    .level(),
    .rise(xtal_rise)
  );

  pin_sync u_mode_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(clock_mode_pin),
    .level(mode_level),
    .rise()
  );

  timer_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .xtal_rise(xtal_rise),
    .prescale_sel(st.prescale),
    .tick(tick)
  );

  // ****************************************************************
  // Register decode and read mux
  // ****************************************************************

  // Address hit: only the four word addresses answer without error
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `CTRL_ADDR) || (a == `COUNT_ADDR) || (a == `STATUS_ADDR) || (a == `MASK_ADDR);
  endfunction

  // Read data; unimplemented bits and unmapped addresses read zero
  function automatic logic [31:0] read_word(input logic [11:0] a, input timer_state_t s);
    read_word = 32'h00000000;
    case (a)
      `CTRL_ADDR: read_word = {21'h000000, s.level, s.vector};
      `COUNT_ADDR: read_word = {23'h000000, s.prescale, s.modulus};
      `STATUS_ADDR: read_word = {30'h00000000, s.status};
      `MASK_ADDR: read_word = {30'h00000000, s.mask};
      default: read_word = 32'h00000000;
    endcase
  endfunction

  // Write commits only at the access edge where pready is high
  assign wr = psel & penable & st.pready & pwrite;
  assign ctrl_wr = wr & (paddr == `CTRL_ADDR);
  assign count_wr = wr & (paddr == `COUNT_ADDR);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    next_st = st;
    expire = 1'b0;
    overrun = 1'b0;
    claim = 1'b0;

    // Bus answer: one wait-free access phase after every setup cycle
    next_st.pready = psel & ~penable;
    next_st.pslverr = 1'b0;
    if (psel && !penable)
    begin
      next_st.prdata = read_word(paddr, st);
      next_st.pslverr = ~addr_hit(paddr);
    end

    // Strap capture waits for the synchroniser to carry the reset-time level
    if (st.strap_cnt != `STRAP_DONE)
      next_st.strap_cnt = st.strap_cnt + 2'h1;
    if (st.strap_cnt == `STRAP_SAMPLE_CYCLE)
      next_st.prescale = ~mode_level;

    // Modulus counter runs whatever the request level is
    if (tick && st.modulus != 8'h00)
    begin
      if (st.count <= 8'h01)
      begin
        next_st.count = st.modulus;
        expire = 1'b1;
      end
      else
        next_st.count = st.count - 8'h01;
    end

    // Register writes; a modulus write restarts the interval from the new value
    if (ctrl_wr)
    begin
      next_st.level = pwdata[`CTRL_LEVEL_MSB:`CTRL_LEVEL_LSB];
      next_st.vector = pwdata[`CTRL_VECTOR_MSB:`CTRL_VECTOR_LSB];
    end
    if (count_wr)
    begin
      next_st.prescale = pwdata[`COUNT_PRESCALE_BIT];
      next_st.modulus = pwdata[`COUNT_MODULUS_MSB:`COUNT_MODULUS_LSB];
      next_st.count = pwdata[`COUNT_MODULUS_MSB:`COUNT_MODULUS_LSB];
    end
    if (wr && paddr == `MASK_ADDR)
      next_st.mask = pwdata[1:0];
    if (wr && paddr == `STATUS_ADDR)
      next_st.status = st.status & ~pwdata[1:0];

    // Acknowledge: timer claims its own level before any external source
    next_st.vec_valid = 1'b0;
    next_st.ext_iack = 1'b0;
    if (iack)
    begin
      if (st.pending && iack_level == st.irq_level)
      begin
        claim = 1'b1;
        next_st.pending = 1'b0;
        next_st.vec_valid = 1'b1;
        next_st.vec = st.vector;
      end
      else
        next_st.ext_iack = (ext_irq_level == iack_level);
    end

    // A fresh expiry wins over the acknowledge that clears the request
    overrun = expire & st.pending & ~claim;
    if (expire && next_st.level != 3'h0)
      next_st.pending = 1'b1;
    if (next_st.level == 3'h0)
      next_st.pending = 1'b0;

    // Sticky events, set beats the write-one clear
    if (expire)
      next_st.status[`EVT_EXPIRE_BIT] = 1'b1;
    if (overrun)
      next_st.status[`EVT_OVERRUN_BIT] = 1'b1;
    next_st.irq = |(next_st.status & next_st.mask);

    next_st.irq_level = next_st.pending ? next_st.level : 3'h0;
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Prescale bit is left at zero here and loaded from the strap after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.level <= `CTRL_LEVEL_RESET;
      st.modulus <= `COUNT_MODULUS_RESET;
      st.vector <= `CTRL_VECTOR_RESET;
    end
    else
      st <= next_st;
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign timer_request_level = st.irq_level;
  assign vector_valid = st.vec_valid;
  assign vector_out = st.vec;
  assign ext_iack = st.ext_iack;
  assign irq = st.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_CTRL_UPPER_ZERO: assert property (
    (psel && penable && pready && !pwrite && paddr == `CTRL_ADDR) |-> prdata[31:11] == 21'h000000)
    else $error("control register upper bits not zero");

  AST_LEVEL_MATCH: assert property (
    (timer_request_level == 3'h0) || (st.level != 3'h0 && timer_request_level == st.level))
    else $error("request level differs from the level field");

  AST_TIMER_FIRST: assert property (
    (iack && st.pending && iack_level == st.irq_level) |=> (vector_valid && !ext_iack))
    else $error("timer did not win the acknowledge");

  AST_COUNT_RUNS: assert property (
    (tick && st.modulus != 8'h00 && st.level == 3'h0 && !count_wr) |=>
    st.count == (($past(st.count) <= 8'h01) ? $past(st.modulus) : $past(st.count) - 8'h01))
    else $error("counter stopped while requests disabled");

  AST_VECTOR_VALUE: assert property (
    vector_valid |-> vector_out == $past(st.vector))
    else $error("wrong vector on acknowledge");

  AST_ZERO_MODULUS: assert property (
    (st.modulus == 8'h00 && !count_wr) |=> !$rose(st.status[0]) && st.count == $past(st.count))
    else $error("timer expired with zero modulus");

  AST_STRAP_LOAD: assert property (
    (st.strap_cnt == 2'h2) |=> st.prescale == !$past(mode_level))
    else $error("prescale bit not loaded from the clock mode pin");

  AST_REQUEST_HELD: assert property (
    (timer_request_level != 3'h0 && !iack && !ctrl_wr) |=> timer_request_level == $past(timer_request_level))
    else $error("request dropped without acknowledge");

  AST_RESET_STATE: assert property (
    (st.strap_cnt == 2'h0) |-> (st.level == 3'h0 && st.modulus == 8'h00 && st.vector == 8'h0F))
    else $error("wrong register state after reset");

  AST_READY_ONE_CYCLE: assert property (
    (psel && !penable) |=> pready ##1 !pready)
    else $error("pready not a single access cycle");

  AST_PREADY_AFTER_SETUP: assert property (
    pready |-> $past(psel && !penable))
    else $error("pready without a setup cycle");

  AST_UNMAPPED_ERROR: assert property (
    (psel && !penable && !addr_hit(paddr)) |=> (pready && pslverr))
    else $error("unmapped address answered without error");

  AST_MAPPED_NO_ERROR: assert property (
    (psel && !penable && addr_hit(paddr)) |=> (pready && !pslverr))
    else $error("mapped address answered with error");

  AST_UNMAPPED_WRITE_IGNORED: assert property (
    (wr && !addr_hit(paddr)) |=> (st.level == $past(st.level) && st.vector == $past(st.vector)
    && st.modulus == $past(st.modulus) && st.mask == $past(st.mask)))
    else $error("unmapped write changed a register");

  AST_COUNT_UPPER_ZERO: assert property (
    (psel && penable && pready && !pwrite && paddr == `COUNT_ADDR) |-> prdata[31:9] == 23'h000000)
    else $error("count register upper bits not zero");

  AST_CTRL_WRITE: assert property (
    ctrl_wr |=> (st.level == $past(pwdata[`CTRL_LEVEL_MSB:`CTRL_LEVEL_LSB])
    && st.vector == $past(pwdata[`CTRL_VECTOR_MSB:`CTRL_VECTOR_LSB])))
    else $error("control write not taken");

  AST_PRESCALE_WRITE: assert property (
    count_wr |=> st.prescale == $past(pwdata[`COUNT_PRESCALE_BIT]))
    else $error("prescale bit not taken from the write");

  AST_MODULUS_WRITE: assert property (
    count_wr |=> (st.modulus == $past(pwdata[`COUNT_MODULUS_MSB:`COUNT_MODULUS_LSB])
    && st.count == $past(pwdata[`COUNT_MODULUS_MSB:`COUNT_MODULUS_LSB])))
    else $error("modulus write not taken");

  AST_MODULUS_HELD: assert property (
    !count_wr |=> st.modulus == $past(st.modulus))
    else $error("modulus changed without a write");

  AST_COUNT_IDLE: assert property (
    (!tick && !count_wr) |=> st.count == $past(st.count))
    else $error("counter moved without a prescaler tick");

  AST_DISABLED_QUIET: assert property (
    (st.level == 3'h0 && !ctrl_wr) |=> timer_request_level == 3'h0)
    else $error("request raised while disabled");

  AST_EXPIRE_REQUEST: assert property (
    (expire && st.level != 3'h0 && !ctrl_wr) |=> timer_request_level == $past(st.level))
    else $error("expiry did not raise the request");

  AST_CLAIM_CLEARS: assert property (
    (claim && !expire) |=> timer_request_level == 3'h0)
    else $error("request not cleared by the acknowledge");

  AST_VECTOR_ON_CLAIM: assert property (
    vector_valid |-> $past(iack && st.pending && iack_level == st.irq_level))
    else $error("vector given without a matching acknowledge");

  AST_EXT_ONLY_MATCH: assert property (
    ext_iack |-> $past(iack && iack_level == ext_irq_level && !claim))
    else $error("acknowledge passed on wrongly");

  AST_EXPIRE_FLAG: assert property (
    expire |=> st.status[`EVT_EXPIRE_BIT])
    else $error("expiry flag not set");

  AST_OVERRUN_FLAG: assert property (
    (expire && st.pending && !claim) |=> st.status[`EVT_OVERRUN_BIT])
    else $error("overrun flag not set");

  AST_FLAG_CLEAR_ONLY: assert property (
    $fell(st.status[`EVT_EXPIRE_BIT]) |-> $past(wr && paddr == `STATUS_ADDR && pwdata[`EVT_EXPIRE_BIT]))
    else $error("expiry flag cleared without a write");

  COV_EXPIRE_ACK: cover property (timer_request_level != 3'h0 ##[1:1000] vector_valid);
  COV_EXT_ACK: cover property (iack ##1 ext_iack);
  COV_OVERRUN: cover property ($rose(st.status[1]));
  COV_IRQ: cover property ($rose(irq));

endmodule

// file: pkg/timer_params.svh
// Register map, field positions, reset values and timing counts of the periodic timer
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define CTRL_INDEX 10'h022
`define COUNT_INDEX 10'h024
`define CTRL_ADDR {`CTRL_INDEX, 2'b00}
`define COUNT_ADDR {`COUNT_INDEX, 2'b00}
`define STATUS_ADDR 12'h0A0
`define MASK_ADDR 12'h0A4

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_LEVEL_MSB 10
`define CTRL_LEVEL_LSB 8
`define CTRL_VECTOR_MSB 7
`define CTRL_VECTOR_LSB 0
`define COUNT_PRESCALE_BIT 8
`define COUNT_MODULUS_MSB 7
`define COUNT_MODULUS_LSB 0
`define EVT_EXPIRE_BIT 0
`define EVT_OVERRUN_BIT 1

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define CTRL_LEVEL_RESET 3'h0
`define CTRL_VECTOR_RESET 8'h0F
`define COUNT_MODULUS_RESET 8'h00
`define XTAL_EDGES_PER_STEP 2'h3
`define PRESCALE_LAST 9'h1FF
`define STRAP_SAMPLE_CYCLE 2'h2
`define STRAP_DONE 2'h3

`endif

// file: pkg/timer_types_pkg.sv
// State types shared by the periodic timer modules
package timer_types_pkg;

  // Synchroniser chain, last stage used for edge detection
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_t;

  // Crystal quarter counter and optional divide by 512
  typedef struct packed {
    logic [1:0] quarter;
    logic [8:0] pre;
    logic tick;
  } prescale_state_t;

  // Register file, modulus counter, request and bus answer
  typedef struct packed {
    logic [2:0] level;
    logic [7:0] vector;
    logic prescale;
    logic [7:0] modulus;
    logic [7:0] count;
    logic pending;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic [2:0] irq_level;
    logic vec_valid;
    logic [7:0] vec;
    logic ext_iack;
    logic [1:0] strap_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } timer_state_t;

endpackage

// file: rtl/pin_sync.sv
// Two-stage synchroniser for a pin, with rising-edge detect after the second stage
module pin_sync
  import timer_types_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic pin,
  output logic level,
  output logic rise
);

  sync_state_t st;
  sync_state_t next_st;

  // Shift chain; the first stage feeds only the second
  always_comb
  begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    // Reset high so a pin already high at release gives no false edge
    if (!presetn)
      st <= '1;
    else
      st <= next_st;
  end

  assign level = st.s2;
  assign rise = st.s2 & ~st.s3;

endmodule

// file: rtl/timer_prescaler.sv
// Prescaler: four crystal edges per step, then optional divide by 512
`include "timer_params.svh"
module timer_prescaler
  import timer_types_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic xtal_rise,
  input logic prescale_sel,
  output logic tick
);

  prescale_state_t st;
  prescale_state_t next_st;

  // Counts crystal edges; the 512 stage only advances on a full step
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (xtal_rise)
    begin
      next_st.quarter = st.quarter + 2'h1;
      if (st.quarter == `XTAL_EDGES_PER_STEP)
      begin
        if (!prescale_sel)
          next_st.tick = 1'b1;
        else
        begin
          next_st.pre = st.pre + 9'h001;
          next_st.tick = (st.pre == `PRESCALE_LAST);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_TICK_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
    st.tick |-> $past(xtal_rise && st.quarter == 2'h3 && (!prescale_sel || st.pre == 9'h1FF)))
    else $error("prescaler tick without a full crystal step");

endmodule

// file: tb/irq_ack_model.sv
// Processor side model: acknowledges the highest pending level after a wait
module irq_ack_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] timer_request_level,
  input wire logic [2:0] ext_irq_level,
  input wire logic vector_valid,
  input wire logic [7:0] vector_out,
  input wire logic ext_iack,
  input wire logic [4:0] ack_wait,
  output logic iack,
  output logic [2:0] iack_level,
  output int vec_cnt,
  output int ext_cnt,
  output logic [7:0] last_vec
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt;
  logic iack_d;
  logic [2:0] top;
  // Highest of the two requesters wins the acknowledge
  assign top = (timer_request_level > ext_irq_level) ? timer_request_level : ext_irq_level;
  // Skip the cycle the answer lands, so a dropped request is never acked twice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      iack <= 1'b0;
      iack_d <= 1'b0;
      iack_level <= 3'h0;
      cnt <= 5'h00;
      vec_cnt <= 0;
      ext_cnt <= 0;
      last_vec <= 8'h00;
    end
    else
    begin
      iack <= 1'b0;
      iack_d <= iack;
      if (top != 3'h0 && !iack && !iack_d)
      begin
        if (cnt >= ack_wait)
        begin
          iack <= 1'b1;
          iack_level <= top;
          cnt <= 5'h00;
        end
        else
          cnt <= cnt + 5'h01;
      end
      if (vector_valid)
      begin
        vec_cnt <= vec_cnt + 1;
        last_vec <= vector_out;
      end
      if (ext_iack)
        ext_cnt <= ext_cnt + 1;
    end
  end
endmodule

// file: tb/test_periodic_timer.sv
// Self-checking bench for the periodic interrupt timer
`include "timer_params.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %h seen %h", n, e, g); end end
module test_periodic_timer;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, iack, vector_valid, ext_iack, irq;
  logic clock_mode_pin = 0;
  logic [1:0] xcnt = 0;
  logic [2:0] iack_level, timer_request_level;
  logic [2:0] ext_irq_level = 0;
  logic [7:0] vector_out, last_vec;
  logic [4:0] ack_wait = 5'h01;
  int error_cnt = 0, check_count = 0, n, v0, e0, vec_cnt, ext_cnt;
  row_t rows[4] = '{'{`CTRL_ADDR, 32'hFFFFFFFF, 32'h000007FF, 1'b0},
    '{`COUNT_ADDR, 32'hFFFFFFFF, 32'h000001FF, 1'b0},
    '{`MASK_ADDR, 32'hFFFFFFFF, 32'h00000003, 1'b0},
    '{12'h0FC, 32'hFFFFFFFF, 32'h00000000, 1'b1}};
  periodic_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_input(xcnt[1]), .clock_mode_pin(clock_mode_pin), .iack(iack), .iack_level(iack_level),
    .ext_irq_level(ext_irq_level), .timer_request_level(timer_request_level), .vector_valid(vector_valid),
    .vector_out(vector_out), .ext_iack(ext_iack), .irq(irq));
  irq_ack_model cpu (.pclk(pclk), .presetn(presetn), .timer_request_level(timer_request_level),
    .ext_irq_level(ext_irq_level), .vector_valid(vector_valid), .vector_out(vector_out),
    .ext_iack(ext_iack), .ack_wait(ack_wait), .iack(iack), .iack_level(iack_level),
    .vec_cnt(vec_cnt), .ext_cnt(ext_cnt), .last_vec(last_vec));
  // Clock and a crystal at a quarter of it, one rising edge every 4 cycles
  always #12.5 pclk = ~pclk;
  always @(posedge pclk)
    xcnt <= xcnt + 2'h1;
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; wait states allowed, pready is polled for up to 50 cycles
  task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask
  // Cycles from one request rise to the next, bounded
  task automatic period(output int c);
    c = 0;
    while (timer_request_level !== 3'h0 && c < 20000)
    begin
      @(negedge pclk);
      c++;
    end
    while (timer_request_level === 3'h0 && c < 20000)
    begin
      @(negedge pclk);
      c++;
    end
    if (c >= 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask
  // Reset for 10 cycles with the strap set, then let the strap settle
  task automatic do_reset(input logic pin);
    presetn <= 1'b0;
    clock_mode_pin <= pin;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  initial
  begin
    do_reset(1'b0);
    apb(`CTRL_ADDR, 0, 0);
    `CHK("ctrl rst", 32'h0000000F, rd)
    apb(`COUNT_ADDR, 0, 0);
    `CHK("count rst", 32'h00000100, rd)
    foreach (rows[i])
    begin
      apb(rows[i].a, rows[i].d, 1);
      apb(rows[i].a, 0, 0);
      `CHK("row rd", rows[i].r, rd)
      `CHK("row err", rows[i].e, er)
    end
    $display("done: registers");
    do_reset(1'b1);
    apb(`COUNT_ADDR, 0, 0);
    `CHK("strap", 32'h00000000, rd)
    apb(`COUNT_ADDR, 32'h00000004, 1);
    apb(`CTRL_ADDR, 32'h000003A5, 1);
    period(n);
    period(n);
    `CHK("period", 64, n)
    `CHK("vector", 8'hA5, last_vec)
    for (int l = 1; l < 8; l++)
    begin
      apb(`CTRL_ADDR, {21'h0, l[2:0], 8'hA5}, 1);
      period(n);
      `CHK("level", l[2:0], timer_request_level)
    end
    $display("done: period and levels");
    ack_wait <= 5'h14;
    period(n);
    period(n);
    `CHK("slow ack", 64, n)
    apb(`CTRL_ADDR, 32'h000003A5, 1);
    ext_irq_level <= 3'h3;
    period(n);
    v0 = vec_cnt;
    e0 = ext_cnt;
    period(n);
    period(n);
    `CHK("claims", v0 + 2, vec_cnt)
    `CHK("ext acks", 1'b1, ext_cnt != e0)
    @(posedge pclk);
    ext_irq_level <= 3'h0;
    $display("done: acknowledge");
    apb(`CTRL_ADDR, 32'h000000A5, 1);
    apb(`STATUS_ADDR, 32'h00000003, 1);
    v0 = 0;
    repeat (150)
    begin
      @(negedge pclk);
      v0 = v0 | (timer_request_level != 3'h0);
    end
    `CHK("disabled", 0, v0)
    apb(`STATUS_ADDR, 0, 0);
    `CHK("runs", 32'h00000001, rd)
    apb(`MASK_ADDR, 32'h00000001, 1);
    @(negedge pclk);
    `CHK("irq on", 1'b1, irq)
    apb(`MASK_ADDR, 32'h00000000, 1);
    @(negedge pclk);
    `CHK("irq mask", 1'b0, irq)
    apb(`COUNT_ADDR, 32'h00000000, 1);
    apb(`STATUS_ADDR, 32'h00000003, 1);
    apb(`MASK_ADDR, 32'h00000001, 1);
    repeat (150) @(posedge pclk);
    apb(`STATUS_ADDR, 0, 0);
    `CHK("mod zero", 32'h00000000, rd)
    `CHK("irq off", 1'b0, irq)
    $display("done: disable and stop");
    apb(`COUNT_ADDR, 32'h00000101, 1);
    apb(`CTRL_ADDR, 32'h000002A5, 1);
    period(n);
    period(n);
    `CHK("prescale", 8192, n)
    $display("done: prescale");
    wrap_up();
  end
endmodule
